// File: core/i2crs_device.sv
// slave end: address match, register pointer, write data and read data on the link
// assumes link_clk runs freely and much faster than the serial clock; writes leave on clk
`timescale 1ns/10ps
`default_nettype none
module i2crs_device import i2crs_pkg::*; #(
    parameter int BUF_DEPTH = I2CRS_BUF_DEPTH
) (
    // clocks and reset
    input  wire logic       link_clk,
    input  wire logic       clk,
    input  wire logic       reset_n,
    // link
    i2crs_link_if.dev       link,
    // straps and mode
    input  wire logic       addr_sel,
    input  wire logic       auto_inc_en,
    // register write stream, clk domain
    output logic            wr_valid,
    input  wire logic       wr_ready,
    output logic [7:0]      wr_reg,
    output logic [7:0]      wr_data
);

    localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
    localparam int CW = $clog2(BUF_DEPTH + 1);

    logic              rst_meta;
    logic              rst_l_n;
    logic [2:0]        scl_sh;
    logic [2:0]        sda_sh;
    logic [2:0]        sel_sh;
    logic              scl_f;
    logic              sda_f;
    logic              sel_f;
    logic              scl_p;
    logic              sda_p;
    logic              ai_meta;
    logic              ai_l;
    logic              scl_rise;
    logic              scl_fall;
    logic              start_c;
    logic              stop_c;
    logic              active;
    logic              ack_now;
    logic              wr_event;
    logic [6:0]        my_addr;
    logic [7:0]        next_ptr;

    i2crs_dev_state_e  state;
    logic [3:0]        bit_cnt;
    logic [7:0]        rx_sh;
    logic [7:0]        tx_sh;
    logic [7:0]        ptr;
    logic              rnw;
    logic              acked;
    logic              sda_oe;
    logic [7:0]        regs [I2CRS_REG_COUNT];

    logic [15:0]       buf_mem [BUF_DEPTH];
    logic [PW-1:0]     wp;
    logic [PW-1:0]     rp;
    logic [CW-1:0]     cnt;
    logic              pop;
    logic [15:0]       xfer_word;
    logic              req_tgl;
    logic              ack_meta_l;
    logic              ack_sync_l;
    logic              busy;
    logic              req_meta;
    logic              req_sync;
    logic              req_seen;
    logic              ack_tgl;

    assign link.dev_sda_o  = 1'h0;
    assign link.dev_sda_oe = sda_oe;

    // reset carried into the link domain
    always_ff @(posedge link_clk) begin
        rst_meta <= reset_n;
        rst_l_n  <= rst_meta;
    end

    // pins through three stages; a change counts once stages two and three agree
    always_ff @(posedge link_clk) begin
        if (!rst_l_n) begin
            scl_sh <= I2CRS_SYNC_IDLE;
            sda_sh <= I2CRS_SYNC_IDLE;
            sel_sh <= 3'h0;
            scl_f  <= 1'h1;
            sda_f  <= 1'h1;
            sel_f  <= 1'h0;
            scl_p  <= 1'h1;
            sda_p  <= 1'h1;
        end else begin
            scl_sh <= {scl_sh[1:0], link.scl};
            sda_sh <= {sda_sh[1:0], link.sda};
            sel_sh <= {sel_sh[1:0], addr_sel};
            if (scl_sh[1] == scl_sh[2]) begin
                scl_f <= scl_sh[2];
            end
            if (sda_sh[1] == sda_sh[2]) begin
                sda_f <= sda_sh[2];
            end
            if (sel_sh[1] == sel_sh[2]) begin
                sel_f <= sel_sh[2];
            end
            scl_p <= scl_f;
            sda_p <= sda_f;
        end
    end

    // mode level from the clk domain
    always_ff @(posedge link_clk) begin
        if (!rst_l_n) begin
            ai_meta <= 1'h0;
            ai_l    <= 1'h0;
        end else begin
            ai_meta <= auto_inc_en;
            ai_l    <= ai_meta;
        end
    end

    assign scl_rise = scl_f && !scl_p;
    assign scl_fall = !scl_f && scl_p;
    assign start_c  = scl_f && scl_p && sda_p && !sda_f;
    assign stop_c   = scl_f && scl_p && !sda_p && sda_f;
    assign active   = (state != I2CRS_D_IDLE) && (state != I2CRS_D_IGNORE);
    assign my_addr  = sel_f ? I2CRS_ADDR_SEL_HIGH : I2CRS_ADDR_SEL_LOW;
    assign next_ptr = ai_l ? 8'(ptr + 8'h01) : ptr;
    assign wr_event = scl_rise && (bit_cnt == I2CRS_ACK_SLOT) &&
                      (state == I2CRS_D_DATA) && acked && !start_c && !stop_c;

    // acknowledge decision for the byte just received
    always_comb begin
        ack_now = 1'h0;
        case (state)
            I2CRS_D_ADDR: ack_now = (rx_sh[7:1] == my_addr);
            I2CRS_D_REG:  ack_now = 1'h1;
            I2CRS_D_DATA: ack_now = (cnt != CW'(BUF_DEPTH));
            default:      ack_now = 1'h0;
        endcase
    end

    // byte engine; any data change with clock high restarts or ends the session
    always_ff @(posedge link_clk) begin
        if (!rst_l_n) begin
            state   <= I2CRS_D_IDLE;
            bit_cnt <= 4'h0;
            rx_sh   <= 8'h00;
            tx_sh   <= 8'h00;
            ptr     <= 8'h00;
            rnw     <= 1'h0;
            acked   <= 1'h0;
            sda_oe  <= 1'h0;
        end else if (start_c) begin
            state   <= I2CRS_D_ADDR;
            bit_cnt <= 4'h0;
            sda_oe  <= 1'h0;
        end else if (stop_c) begin
            state   <= I2CRS_D_IDLE;
            bit_cnt <= 4'h0;
            sda_oe  <= 1'h0;
        end else if (scl_rise && active) begin
            if (bit_cnt != I2CRS_ACK_SLOT) begin
                bit_cnt <= 4'(bit_cnt + 4'h1);
                rx_sh   <= {rx_sh[6:0], sda_f};
                if (state == I2CRS_D_TX) begin
                    tx_sh <= {tx_sh[6:0], 1'h0};
                end
            end else begin
                bit_cnt <= 4'h0;
                case (state)
                    I2CRS_D_ADDR: begin
                        if (!acked) begin
                            state <= I2CRS_D_IGNORE;
                        end else if (rnw == I2CRS_DIR_READ) begin
                            tx_sh <= regs[ptr];
                            state <= I2CRS_D_TX;
                        end else begin
                            state <= I2CRS_D_REG;
                        end
                    end
                    I2CRS_D_REG: begin
                        ptr   <= rx_sh;
                        state <= I2CRS_D_DATA;
                    end
                    I2CRS_D_DATA: begin
                        if (acked) begin
                            ptr <= next_ptr;
                        end
                    end
                    I2CRS_D_TX: begin
                        if (sda_f) begin
                            state <= I2CRS_D_IGNORE;
                        end else begin
                            tx_sh <= regs[next_ptr];
                            ptr   <= next_ptr;
                        end
                    end
                    default: begin
                        state <= I2CRS_D_IGNORE;
                    end
                endcase
            end
        end else if (scl_fall && active) begin
            if (bit_cnt == I2CRS_ACK_SLOT && state != I2CRS_D_TX) begin
                sda_oe <= ack_now;
                acked  <= ack_now;
                if (state == I2CRS_D_ADDR) begin
                    rnw <= rx_sh[0];
                end
            end else if (state == I2CRS_D_TX && bit_cnt != I2CRS_ACK_SLOT) begin
                sda_oe <= !tx_sh[7];
            end else begin
                sda_oe <= 1'h0;
            end
        end else if (!active) begin
            sda_oe <= 1'h0;
        end
    end

    // register image; a written value lands on the rising edge of its ack
    always_ff @(posedge link_clk) begin
        if (!rst_l_n) begin
            for (int i = 0; i < I2CRS_REG_COUNT; i++) begin
                regs[i] <= I2CRS_REG_RESET;
            end
        end else if (wr_event) begin
            regs[ptr] <= rx_sh;
        end
    end

    // write buffer between the engine and the domain crossing
    assign busy = (req_tgl != ack_sync_l);
    assign pop  = (cnt != CW'(0)) && !busy;

    always_ff @(posedge link_clk) begin
        if (!rst_l_n) begin
            wp  <= '0;
            rp  <= '0;
            cnt <= '0;
        end else begin
            if (wr_event) begin
                buf_mem[wp] <= {ptr, rx_sh};
                wp <= (wp == PW'(BUF_DEPTH - 1)) ? '0 : PW'(wp + 1'h1);
            end
            if (pop) begin
                rp <= (rp == PW'(BUF_DEPTH - 1)) ? '0 : PW'(rp + 1'h1);
            end
            cnt <= CW'(cnt + CW'(wr_event) - CW'(pop));
        end
    end

    // toggle handshake, link side
    always_ff @(posedge link_clk) begin
        if (!rst_l_n) begin
            xfer_word  <= 16'h0000;
            req_tgl    <= 1'h0;
            ack_meta_l <= 1'h0;
            ack_sync_l <= 1'h0;
        end else begin
            ack_meta_l <= ack_tgl;
            ack_sync_l <= ack_meta_l;
            if (pop) begin
                xfer_word <= buf_mem[rp];
                req_tgl   <= !req_tgl;
            end
        end
    end

    // toggle handshake, clk side; the word is stable while a request is open
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            req_meta <= 1'h0;
            req_sync <= 1'h0;
            req_seen <= 1'h0;
            ack_tgl  <= 1'h0;
            wr_valid <= 1'h0;
            wr_reg   <= 8'h00;
            wr_data  <= 8'h00;
        end else begin
            req_meta <= req_tgl;
            req_sync <= req_meta;
            if (wr_valid && wr_ready) begin
                wr_valid <= 1'h0;
                ack_tgl  <= !ack_tgl;
            end else if (!wr_valid && req_sync != req_seen) begin
                wr_valid <= 1'h1;
                wr_reg   <= xfer_word[15:8];
                wr_data  <= xfer_word[7:0];
                req_seen <= req_sync;
            end
        end
    end

endmodule : i2crs_device
`default_nettype wire

// File: core/i2crs_pkg.sv
// constants, state types and link timing for the two-wire register access slave and its master
// assumes a 25 MHz system clock; the device engine runs on a separate link clock
//
// Behaviour
// - sample data while clock high, change while low
// - data change mid-transaction aborts the transfer
// - data falling with clock high starts session
// - data rising with clock high ends session
// - master makes start/stop; busy from start to stop
// - repeated start handled like a first start
// - bytes are eight bits, msb first, then ack
// - transmitter releases; receiver pulls ninth pulse low
// - addressed device acknowledges every received byte; the device nacks a data byte while its write buffer is full
// - first byte: seven-bit address plus direction bit
// - address 54h when select low, 55h high
// - write: register byte, then data byte
// - written value applied at final ack rising edge
// - master sets register address before reading
// - auto-increment steps addresses across successive bytes
// - master uses auto-increment for command registers only; this master sends one byte per command and never uses it
package i2crs_pkg;

    localparam logic [6:0] I2CRS_ADDR_SEL_LOW  = 7'h54;
    localparam logic [6:0] I2CRS_ADDR_SEL_HIGH = 7'h55;
    localparam logic       I2CRS_DIR_WRITE     = 1'h0;
    localparam logic       I2CRS_DIR_READ      = 1'h1;
    localparam logic [3:0] I2CRS_ACK_SLOT      = 4'h8;
    localparam logic [7:0] I2CRS_REG_RESET     = 8'h00;
    localparam logic [2:0] I2CRS_SYNC_IDLE     = 3'h7;
    localparam int         I2CRS_REG_COUNT     = 256;
    localparam int         I2CRS_BUF_DEPTH     = 2;

    // one bit cell is four quarters; two quarters low and two high
    localparam int         I2CRS_CLK_PERIOD_NS = 40;
    localparam int         I2CRS_QTR_NS        = 650;
    localparam int         I2CRS_QTR_CYC       =
        (I2CRS_QTR_NS + I2CRS_CLK_PERIOD_NS - 1) / I2CRS_CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        I2CRS_Q0,
        I2CRS_Q1,
        I2CRS_Q2,
        I2CRS_Q3
    } i2crs_qtr_e;

    typedef enum {
        I2CRS_D_IDLE,
        I2CRS_D_ADDR,
        I2CRS_D_REG,
        I2CRS_D_DATA,
        I2CRS_D_TX,
        I2CRS_D_IGNORE
    } i2crs_dev_state_e;

    typedef enum {
        I2CRS_H_IDLE,
        I2CRS_H_START,
        I2CRS_H_ADDRW,
        I2CRS_H_REG,
        I2CRS_H_WDATA,
        I2CRS_H_RSTART,
        I2CRS_H_ADDRR,
        I2CRS_H_RDATA,
        I2CRS_H_STOP
    } i2crs_host_state_e;

endpackage : i2crs_pkg

// File: core/i2crs_link_if.sv
// open-drain two-wire link between master and device
// each party drives an output value and an enable; the wire level is resolved here
`timescale 1ns/10ps
`default_nettype none
interface i2crs_link_if;

    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic scl;
    logic sda;

    // pulled up unless some enabled driver pulls low
    assign scl = !(host_scl_oe && !host_scl_o);
    assign sda = !(host_sda_oe && !host_sda_o) && !(dev_sda_oe && !dev_sda_o);

    modport host (
        output host_scl_o,
        output host_scl_oe,
        output host_sda_o,
        output host_sda_oe,
        input  sda
    );

    modport dev (
        output dev_sda_o,
        output dev_sda_oe,
        input  scl,
        input  sda
    );

endinterface : i2crs_link_if
`default_nettype wire

// File: core/i2crs_host.sv
// bus master end: one register write or one register read per command
// assumes the device answers on the link; serial clock derived from clk by a quarter divider
`timescale 1ns/10ps
`default_nettype none
module i2crs_host import i2crs_pkg::*; #(
    parameter int QTR_CYC = I2CRS_QTR_CYC
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // link
    i2crs_link_if.host      link,
    // command
    input  wire logic       cmd_valid,
    output logic            cmd_ready,
    input  wire logic       cmd_read,
    input  wire logic [6:0] cmd_dev_addr,
    input  wire logic [7:0] cmd_reg,
    input  wire logic [7:0] cmd_wdata,
    // response
    output logic            rsp_valid,
    output logic            rsp_nack,
    output logic [7:0]      rsp_rdata
);

    localparam int QW = $clog2(QTR_CYC + 1);

    i2crs_host_state_e state;
    i2crs_qtr_e        qtr;
    logic [QW-1:0]     tick;
    logic [3:0]        bit_cnt;
    logic [7:0]        sh;
    logic [6:0]        dev_addr;
    logic [7:0]        reg_addr;
    logic [7:0]        wdata;
    logic              rd;
    logic              err;
    logic [2:0]        sda_sh;
    logic              sda_f;
    logic              want_scl;
    logic              want_sda;
    logic              scl_lvl;
    logic              sda_lvl;
    logic              qtr_end;
    logic              in_byte;
    logic              tx_byte;

    assign cmd_ready = (state == I2CRS_H_IDLE);
    assign qtr_end   = (tick == QW'(QTR_CYC - 1));
    assign in_byte   = (state == I2CRS_H_ADDRW) || (state == I2CRS_H_REG) ||
                       (state == I2CRS_H_WDATA) || (state == I2CRS_H_ADDRR) ||
                       (state == I2CRS_H_RDATA);
    assign tx_byte   = in_byte && (state != I2CRS_H_RDATA);

    assign link.host_scl_o  = 1'h0;
    assign link.host_sda_o  = 1'h0;
    assign link.host_scl_oe = !scl_lvl;
    assign link.host_sda_oe = !sda_lvl;

    // data line from the pin, filtered on agreement of stages two and three
    always_ff @(posedge clk) begin
        sda_sh <= {sda_sh[1:0], link.sda};
        if (!reset_n) begin
            sda_f <= 1'h1;
        end else if (sda_sh[1] == sda_sh[2]) begin
            sda_f <= sda_sh[2];
        end
    end

    // line levels for each quarter of the current cell
    always_comb begin
        want_scl = 1'h1;
        want_sda = 1'h1;
        case (state)
            I2CRS_H_IDLE: begin
                want_scl = 1'h1;
                want_sda = 1'h1;
            end
            I2CRS_H_START: begin
                want_scl = (qtr == I2CRS_Q0) || (qtr == I2CRS_Q1);
                want_sda = (qtr == I2CRS_Q0);
            end
            I2CRS_H_RSTART: begin
                want_scl = (qtr == I2CRS_Q1) || (qtr == I2CRS_Q2);
                want_sda = (qtr == I2CRS_Q0) || (qtr == I2CRS_Q1);
            end
            I2CRS_H_STOP: begin
                want_scl = (qtr != I2CRS_Q0);
                want_sda = (qtr == I2CRS_Q2) || (qtr == I2CRS_Q3);
            end
            default: begin
                want_scl = (qtr == I2CRS_Q1) || (qtr == I2CRS_Q2);
                // ack slot and every read bit are released; read ends in a nack
                want_sda = (tx_byte && bit_cnt != I2CRS_ACK_SLOT) ? sh[7] : 1'h1;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            scl_lvl <= 1'h1;
            sda_lvl <= 1'h1;
        end else begin
            scl_lvl <= want_scl;
            sda_lvl <= want_sda;
        end
    end

    // quarter divider
    always_ff @(posedge clk) begin
        if (!reset_n || state == I2CRS_H_IDLE || qtr_end) begin
            tick <= '0;
        end else begin
            tick <= QW'(tick + 1'h1);
        end
    end

    // transfer sequencer; single-byte transfers never lean on auto-increment
    always_ff @(posedge clk) begin
        rsp_valid <= 1'h0;
        if (!reset_n) begin
            state     <= I2CRS_H_IDLE;
            qtr       <= I2CRS_Q0;
            bit_cnt   <= 4'h0;
            sh        <= 8'h00;
            dev_addr  <= 7'h00;
            reg_addr  <= 8'h00;
            wdata     <= 8'h00;
            rd        <= 1'h0;
            err       <= 1'h0;
            rsp_valid <= 1'h0;
            rsp_nack  <= 1'h0;
            rsp_rdata <= 8'h00;
        end else if (state == I2CRS_H_IDLE) begin
            qtr     <= I2CRS_Q0;
            bit_cnt <= 4'h0;
            if (cmd_valid) begin
                dev_addr <= cmd_dev_addr;
                reg_addr <= cmd_reg;
                wdata    <= cmd_wdata;
                rd       <= cmd_read;
                err      <= 1'h0;
                state    <= I2CRS_H_START;
            end
        end else if (qtr_end) begin
            qtr <= i2crs_qtr_e'(qtr + 2'h1);
            if (qtr == I2CRS_Q2 && in_byte) begin
                if (bit_cnt != I2CRS_ACK_SLOT) begin
                    if (!tx_byte) begin
                        sh <= {sh[6:0], sda_f};
                    end
                end else if (sda_f && tx_byte) begin
                    err <= 1'h1;
                end
            end
            if (qtr == I2CRS_Q3) begin
                if (in_byte && bit_cnt != I2CRS_ACK_SLOT) begin
                    bit_cnt <= 4'(bit_cnt + 4'h1);
                    if (tx_byte) begin
                        sh <= {sh[6:0], 1'h0};
                    end
                end else begin
                    bit_cnt <= 4'h0;
                    case (state)
                        I2CRS_H_START: begin
                            sh    <= {dev_addr, I2CRS_DIR_WRITE};
                            state <= I2CRS_H_ADDRW;
                        end
                        I2CRS_H_ADDRW: begin
                            sh    <= reg_addr;
                            state <= err ? I2CRS_H_STOP : I2CRS_H_REG;
                        end
                        I2CRS_H_REG: begin
                            sh <= wdata;
                            if (err) begin
                                state <= I2CRS_H_STOP;
                            end else begin
                                state <= rd ? I2CRS_H_RSTART : I2CRS_H_WDATA;
                            end
                        end
                        I2CRS_H_WDATA: begin
                            state <= I2CRS_H_STOP;
                        end
                        I2CRS_H_RSTART: begin
                            sh    <= {dev_addr, I2CRS_DIR_READ};
                            state <= I2CRS_H_ADDRR;
                        end
                        I2CRS_H_ADDRR: begin
                            state <= err ? I2CRS_H_STOP : I2CRS_H_RDATA;
                        end
                        I2CRS_H_RDATA: begin
                            rsp_rdata <= sh;
                            state     <= I2CRS_H_STOP;
                        end
                        I2CRS_H_STOP: begin
                            rsp_valid <= 1'h1;
                            rsp_nack  <= err;
                            state     <= I2CRS_H_IDLE;
                        end
                        default: begin
                            state <= I2CRS_H_IDLE;
                        end
                    endcase
                end
            end
        end
    end

endmodule : i2crs_host
`default_nettype wire

// File: dv/i2crs_link_properties.sv
// wire-level checks on the link between master and device
// assumes the link levels are sampled on the master clock
`timescale 1ns/10ps
`default_nettype none
module i2crs_link_properties import i2crs_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // link
    input wire logic host_sda_oe,
    input wire logic dev_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    logic       pc;
    logic       ps;
    logic       st;
    logic       sp;
    logic       up;
    logic       first;
    logic       hit;
    logic [3:0] bitn;
    logic [7:0] shreg;
    assign st  = scl && pc && ps && !sda;
    assign sp  = scl && pc && !ps && sda;
    assign up  = scl && !pc;
    assign hit = shreg[7:1] inside {I2CRS_ADDR_SEL_LOW, I2CRS_ADDR_SEL_HIGH};
    always_ff @(posedge clk) begin
        pc <= scl;
        ps <= sda;
    end
    // bit position and first-byte tracking
    always_ff @(posedge clk) begin
        if (!reset_n || st) begin
            bitn  <= 4'h0;
            first <= st;
        end else if (up) begin
            bitn  <= (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
            first <= first && (bitn != 4'h8);
            if (bitn != 4'h8) begin
                shreg <= {shreg[6:0], sda};
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_dev_change_low: assert property ($changed(dev_sda_oe) |-> !scl)
        else $error("device moved data while clock high");
    a_start_from_host: assert property (st |-> host_sda_oe)
        else $error("start not made by master");
    a_stop_quiet: assert property (sp |=> !dev_sda_oe [*8])
        else $error("device drove after stop");
    a_idle_clock_high: assert property (sp |=> scl [*8])
        else $error("clock moved right after stop");
    a_addr_ack_slot: assert property (up && first && dev_sda_oe |-> bitn == 4'h8)
        else $error("device drove inside address byte");
    a_match_ack: assert property (up && first && bitn == 4'h8 && dev_sda_oe |-> hit)
        else $error("device acked foreign address");
    a_mismatch_quiet: assert property (up && first && bitn == 4'h8 && !hit |-> !dev_sda_oe [*8])
        else $error("device answered foreign address");
    a_host_release_ack: assert property (up && first && bitn == 4'h8 |-> !host_sda_oe)
        else $error("master held data in ack slot");
    cover property (st);
    cover property (up && first && bitn == 4'h8 && dev_sda_oe);
    cover property (up && !first && dev_sda_oe && bitn < 4'h8);
endmodule : i2crs_link_properties
`default_nettype wire

// File: dv/i2c_register_access_slave_test.sv
// self-checking bench: master and device joined by the link, random register traffic
// assumes the default link timing of the package
`timescale 1ns/10ps
`default_nettype none
module i2c_register_access_slave_test import i2crs_pkg::*;;
    logic        clk, link_clk, reset_n, cmd_valid, cmd_ready, cmd_read, rsp_valid, rsp_nack;
    logic        addr_sel, auto_inc_en, wr_valid, wr_ready;
    logic [6:0]  cmd_dev_addr, a;
    logic [7:0]  cmd_reg, cmd_wdata, rsp_rdata, wr_reg, wr_data, r, d;
    logic [7:0]  img [256];
    logic [15:0] exp_q [$];
    logic [31:0] seed;
    int          num_errors, num_checks, cycles = 0;
    i2crs_link_if link ();
    i2crs_host i2crs_host_i (.clk(clk), .reset_n(reset_n), .link(link), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_dev_addr(cmd_dev_addr), .cmd_reg(cmd_reg),
        .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_nack(rsp_nack), .rsp_rdata(rsp_rdata));
    i2crs_device i2crs_device_i (.link_clk(link_clk), .clk(clk), .reset_n(reset_n), .link(link),
        .addr_sel(addr_sel), .auto_inc_en(auto_inc_en), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .wr_reg(wr_reg), .wr_data(wr_data));
    i2crs_link_properties i2crs_link_properties_i (.clk(clk), .reset_n(reset_n),
        .host_sda_oe(link.host_sda_oe), .dev_sda_oe(link.dev_sda_oe), .scl(link.scl), .sda(link.sda));
    always #20 clk = ~clk;
    always begin
        #13;
        forever #40 link_clk = ~link_clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    function automatic logic exp_nack(input logic [6:0] da, input logic sel);
        return da != (sel ? I2CRS_ADDR_SEL_HIGH : I2CRS_ADDR_SEL_LOW);
    endfunction : exp_nack
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        num_checks++;
        if (seen !== want || $isunknown(seen)) begin
            num_errors++;
            $display("BAD %0t: saw %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish
    // one command, held for the edge that takes it, then wait for the response pulse
    task automatic xfer(input logic rd, input logic [6:0] da, input logic [7:0] rg, input logic [7:0] dt);
        @(negedge clk);
        {cmd_read, cmd_dev_addr, cmd_reg, cmd_wdata} = {rd, da, rg, dt};
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1) @(negedge clk);
    endtask : xfer
    always @(posedge clk) begin
        if (reset_n && wr_valid && wr_ready) begin
            check({wr_reg, wr_data}, exp_q.size() > 0 ? exp_q.pop_front() : 16'hXXXX);
        end
        cycles++;
        if (cycles == 90000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    initial begin
        {clk, link_clk, reset_n, cmd_valid, cmd_read, cmd_dev_addr, cmd_reg, cmd_wdata} = '0;
        {addr_sel, auto_inc_en, wr_ready, seed, num_errors, num_checks} = {3'b001, 32'hDED0, 64'h0};
        foreach (img[k]) img[k] = I2CRS_REG_RESET;
        repeat (8) @(negedge clk);
        check({14'h0, rsp_valid, wr_valid}, 16'h0);
        reset_n = 1'b1;
        repeat (8) @(negedge clk);
        for (int i = 0; i < 7; i++) begin
            seed = xs(seed);
            addr_sel = i[0];
            auto_inc_en = seed[8];
            r = (i == 0) ? 8'hFF : seed[7:0];
            d = (i == 1) ? 8'h00 : seed[15:8];
            a = addr_sel ? I2CRS_ADDR_SEL_HIGH : I2CRS_ADDR_SEL_LOW;
            repeat (4) @(negedge clk);
            exp_q.push_back({r, d});
            img[r] = d;
            xfer(1'b0, a, r, d);
            check(16'(rsp_nack), 16'(exp_nack(a, addr_sel)));
            xfer(1'b1, a, r, 8'h00);
            check({8'h00, rsp_rdata}, {8'h00, img[r]});
            check(16'(rsp_nack), 16'h0);
            xfer(1'b0, a ^ {seed[9], 6'h01}, seed[23:16], seed[31:24]);
            check(16'(rsp_nack), 16'(exp_nack(a ^ {seed[9], 6'h01}, addr_sel)));
            xfer(1'b1, a, seed[23:16], 8'h00);
            check({8'h00, rsp_rdata}, {8'h00, img[seed[23:16]]});
            $display("test %0d done", i);
        end
        wr_ready = 1'b0;
        for (int j = 0; j < 2; j++) begin
            exp_q.push_back({8'h50 + 8'(j), seed[7:0]});
            xfer(1'b0, a, 8'h50 + 8'(j), seed[7:0]);
        end
        repeat (20) @(negedge clk);
        check({7'h0, wr_valid, wr_reg}, 16'h0150);
        wr_ready = 1'b1;
        repeat (200) @(negedge clk);
        check(16'(exp_q.size()), 16'h0);
        $display("test stall done");
        tally_and_finish();
    end
endmodule : i2c_register_access_slave_test
`default_nettype wire
